// file: dbdl_pkg.sv
// constants shared by the double-buffered converter latch controller
// How it works
// - in single buffering the converter register is left transparent and the input register alone latches each byte.
// - stand-alone single buffering holds input select, second strobe and transfer select low, latch enable high, and pulses the first strobe.
// - whenever a byte must be held, the input register is the latching stage.
// - each write strobe is stretched by wait cycles to the least allowed pulse width with data held valid.
// - the device strobe is made by a one-shot fired on the falling edge of the system write request.
package dbdl_pkg;

  localparam int unsigned CODE_W         = 8;
  localparam int unsigned CLK_PERIOD_NS  = 40;
  // least write strobe low time and least data hold after the rising edge
  localparam int unsigned STROBE_MIN_NS  = 900;
  localparam int unsigned HOLD_MIN_NS    = 50;
  localparam int unsigned SETUP_MIN_NS   = 40;
  localparam int unsigned STROBE_CYC     =
    (STROBE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned HOLD_CYC       =
    (HOLD_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SETUP_CYC      =
    (SETUP_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CNT_W          = 8;
  localparam logic [7:0]  CODE_RESET     = 8'h00;
  localparam logic [7:0]  CODE_FULL      = 8'hFF;

  // operating configuration of the latches
  typedef enum logic [1:0] {
    DBDL_MODE_DOUBLE = 2'h0,
    DBDL_MODE_SINGLE = 2'h1,
    DBDL_MODE_FLOW   = 2'h2
  } dbdl_mode_t;

  // write operations the user may request
  typedef enum logic [1:0] {
    DBDL_OP_LOAD      = 2'h0,
    DBDL_OP_TRANSFER  = 2'h1,
    DBDL_OP_LOAD_MOVE = 2'h2
  } dbdl_op_t;

endpackage : dbdl_pkg

// file: dbdl_strobe_if.sv
// handshake between the sequencer and the strobe one-shot
`timescale 1ns/1ps
`default_nettype none
interface dbdl_strobe_if;
  logic fire_n;      // system write strobe, active low
  logic strobe_low;  // one-shot output, high while device strobe is low
  logic done;        // one cycle after low time plus hold time

  modport seq (output fire_n, input strobe_low, input done);
  modport shot (input fire_n, output strobe_low, output done);
endinterface : dbdl_strobe_if
`default_nettype wire

// file: dbdl_oneshot.sv
// falling-edge one-shot that times the device write strobe and hold
`timescale 1ns/1ps
`default_nettype none
module dbdl_oneshot #(
  parameter int unsigned LOW_CYC  = dbdl_pkg::STROBE_CYC,
  parameter int unsigned HOLD_CYC = dbdl_pkg::HOLD_CYC
) (
  // clock and control
  input  wire logic clk_i,
  input  wire logic reset_i,
  input  wire logic ce_i,
  // sequencer side
  dbdl_strobe_if.shot sif
);
  import dbdl_pkg::*;

  typedef enum logic [1:0] {DBDL_OS_IDLE, DBDL_OS_LOW, DBDL_OS_HOLD}
    dbdl_os_t;

  dbdl_os_t         state_q;
  logic [CNT_W-1:0] cnt_q;
  logic             fire_n_q;
  logic             done_q;

  if (LOW_CYC < 1 || LOW_CYC > 255 || HOLD_CYC < 1 || HOLD_CYC > 255)
    begin : g_bad
    $error("dbdl_oneshot: counts must lie in 1..255");
  end

  // remember last request level to find its falling edge
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      fire_n_q <= 1'b1;
    end else if (ce_i) begin
      fire_n_q <= sif.fire_n;
    end
  end

  // the fixed low time stretches short requests like wait states
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      state_q <= DBDL_OS_IDLE;
      cnt_q   <= '0;
      done_q  <= 1'b0;
    end else if (ce_i) begin
      done_q <= 1'b0;
      unique case (state_q)
        DBDL_OS_IDLE: begin
          if (!sif.fire_n && fire_n_q) begin // falling edge
            state_q <= DBDL_OS_LOW;
            cnt_q   <= CNT_W'(LOW_CYC - 1);
          end
        end
        DBDL_OS_LOW: begin
          if (cnt_q == '0) begin
            state_q <= DBDL_OS_HOLD;
            cnt_q   <= CNT_W'(HOLD_CYC - 1);
          end else begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        DBDL_OS_HOLD: begin
          // data stays put after the rising edge for the hold time
          if (cnt_q == '0) begin
            state_q <= DBDL_OS_IDLE;
            done_q  <= 1'b1;
          end else begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
      endcase
    end
  end

  assign sif.strobe_low = (state_q == DBDL_OS_LOW);
  assign sif.done       = done_q;

endmodule : dbdl_oneshot
`default_nettype wire

// file: dbdl_ctrl.sv
// controller that drives the converter latch pins from byte requests
`timescale 1ns/1ps
`default_nettype none
module dbdl_ctrl #(
  parameter int unsigned STROBE_CYC = dbdl_pkg::STROBE_CYC,
  parameter int unsigned HOLD_CYC   = dbdl_pkg::HOLD_CYC,
  parameter int unsigned SETUP_CYC  = dbdl_pkg::SETUP_CYC
) (
  // clock, reset, enable
  input  wire logic                        clk_i,
  input  wire logic                        reset_i,
  input  wire logic                        ce_i,
  // configuration
  input  wire dbdl_pkg::dbdl_mode_t        mode_i,
  input  wire logic                        freeze_i,
  // request port
  input  wire logic                        cmd_valid_i,
  input  wire dbdl_pkg::dbdl_op_t          cmd_op_i,
  input  wire logic [dbdl_pkg::CODE_W-1:0] cmd_data_i,
  output logic                             cmd_ready_o,
  output logic                             done_o,
  // device pins
  output logic [dbdl_pkg::CODE_W-1:0]      data_o,
  output logic                             input_select_n_o,
  output logic                             input_latch_enable_o,
  output logic                             first_write_strobe_n_o,
  output logic                             second_write_strobe_n_o,
  output logic                             transfer_select_n_o,
  // expected register contents
  output logic [dbdl_pkg::CODE_W-1:0]      input_code_o,
  output logic [dbdl_pkg::CODE_W-1:0]      true_code_o,
  output logic [dbdl_pkg::CODE_W-1:0]      complement_code_o
);
  import dbdl_pkg::*;

  typedef enum logic [2:0] {
    DBDL_ST_IDLE, DBDL_ST_SETUP, DBDL_ST_FIRE, DBDL_ST_WAIT, DBDL_ST_END
  } dbdl_state_t;

  dbdl_state_t      state_q;
  dbdl_mode_t       mode_q;
  dbdl_op_t         op_q;
  logic             phase_move_q;  // current strobe targets transfer
  logic [CNT_W-1:0] setup_q;
  logic             fire_n_q;      // system write strobe, idles high

  dbdl_strobe_if sif ();

  if (SETUP_CYC < 1 || SETUP_CYC > 255) begin : g_bad
    $error("dbdl_ctrl: SETUP_CYC must lie in 1..255");
  end

  // decode helpers, op_loads used in two places and op_moves in one
  function automatic logic op_loads(input dbdl_op_t op);
    op_loads = (op != DBDL_OP_TRANSFER);
  endfunction : op_loads

  function automatic logic op_moves(input dbdl_op_t op);
    op_moves = (op != DBDL_OP_LOAD);
  endfunction : op_moves

  dbdl_oneshot #(
    .LOW_CYC  (STROBE_CYC),
    .HOLD_CYC (HOLD_CYC)
  ) u_shot (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .ce_i    (ce_i),
    .sif     (sif.shot)
  );

  assign sif.fire_n = fire_n_q;

  // sequencer: mode is only taken while idle so pins never glitch mid write
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      state_q      <= DBDL_ST_IDLE;
      mode_q       <= DBDL_MODE_DOUBLE;
      op_q         <= DBDL_OP_LOAD;
      phase_move_q <= 1'b0;
      setup_q      <= '0;
      fire_n_q     <= 1'b1;
    end else if (ce_i) begin
      unique case (state_q)
        DBDL_ST_IDLE: begin
          mode_q <= mode_i;
          if (cmd_valid_i && cmd_ready_o && mode_q != DBDL_MODE_FLOW) begin
            op_q         <= cmd_op_i;
            // single mode leaves the converter open, so only load
            phase_move_q <= !op_loads(cmd_op_i);
            setup_q      <= CNT_W'(SETUP_CYC - 1);
            state_q      <= (mode_q == DBDL_MODE_SINGLE &&
                             !op_loads(cmd_op_i)) ? DBDL_ST_END
                                                  : DBDL_ST_SETUP;
          end
        end
        DBDL_ST_SETUP: begin
          if (setup_q == '0) begin
            state_q <= DBDL_ST_FIRE;
          end else begin
            setup_q <= setup_q - 1'b1;
          end
        end
        DBDL_ST_FIRE: begin
          fire_n_q <= 1'b0;          // falling edge fires the one-shot
          state_q <= DBDL_ST_WAIT;
        end
        DBDL_ST_WAIT: begin
          fire_n_q <= 1'b1;
          if (sif.done) begin
            if (!phase_move_q && op_moves(op_q) &&
                mode_q == DBDL_MODE_DOUBLE) begin
              phase_move_q <= 1'b1;
              setup_q      <= CNT_W'(SETUP_CYC - 1);
              state_q      <= DBDL_ST_SETUP;
            end else begin
              state_q <= DBDL_ST_END;
            end
          end
        end
        DBDL_ST_END: begin
          state_q <= DBDL_ST_IDLE;
        end
        default: begin
          state_q <= DBDL_ST_IDLE;
        end
      endcase
    end
  end

  // request handshake and completion pulse
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      cmd_ready_o <= 1'b0;
      done_o      <= 1'b0;
    end else if (ce_i) begin
      cmd_ready_o <= (state_q == DBDL_ST_IDLE) &&
                     !(cmd_valid_i && cmd_ready_o) &&
                     !(state_q == DBDL_ST_END);
      done_o      <= (state_q == DBDL_ST_END) ||
                     (state_q == DBDL_ST_IDLE && mode_q == DBDL_MODE_FLOW &&
                      cmd_valid_i && cmd_ready_o);
      if (state_q == DBDL_ST_IDLE && mode_q == DBDL_MODE_FLOW) begin
        cmd_ready_o <= 1'b1;       // flow-through takes a byte every cycle
      end
    end
  end

  // data pins: every pin is driven from reset on, none floats high
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      data_o <= CODE_RESET;
    end else if (ce_i) begin
      if (state_q == DBDL_ST_IDLE && cmd_valid_i && cmd_ready_o) begin
        data_o <= cmd_data_i;      // held until the next accept
      end
    end
  end

  // select and strobe pins per configuration
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      input_select_n_o        <= 1'b1;
      input_latch_enable_o    <= 1'b0;
      first_write_strobe_n_o  <= 1'b1;
      second_write_strobe_n_o <= 1'b1;
      transfer_select_n_o     <= 1'b1;
    end else if (ce_i) begin
      // a frozen bus keeps the input register shut
      input_latch_enable_o <= !freeze_i;
      unique case (mode_q)
        DBDL_MODE_FLOW: begin
          // all latches open unless frozen, output follows data pins
          input_select_n_o        <= 1'b0;
          first_write_strobe_n_o  <= 1'b0;
          second_write_strobe_n_o <= 1'b0;
          transfer_select_n_o     <= 1'b0;
        end
        DBDL_MODE_SINGLE: begin
          // converter stays transparent, input register latches
          input_select_n_o        <= 1'b0;
          second_write_strobe_n_o <= 1'b0;
          transfer_select_n_o     <= 1'b0;
          first_write_strobe_n_o  <= !sif.strobe_low;
        end
        default: begin
          // independent selects for input and converter
          input_select_n_o        <= !(state_q != DBDL_ST_IDLE &&
                                       !phase_move_q);
          first_write_strobe_n_o  <= !(sif.strobe_low && !phase_move_q);
          transfer_select_n_o     <= !(state_q != DBDL_ST_IDLE &&
                                       phase_move_q);
          // high strobe or select keeps the converter
          second_write_strobe_n_o <= !(sif.strobe_low && phase_move_q);
        end
      endcase
    end
  end

  // model of both latches, updated on the one-shot done pulse, and every cycle in flow-through while freeze_i is low
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      input_code_o      <= CODE_RESET;
      true_code_o       <= CODE_RESET;
      complement_code_o <= CODE_FULL;
    end else if (ce_i) begin
      if (mode_q == DBDL_MODE_FLOW) begin
        if (!freeze_i) begin
          input_code_o      <= data_o;
          true_code_o       <= data_o;
          complement_code_o <= ~data_o;
        end
      end else if (state_q == DBDL_ST_WAIT && sif.done) begin
        if (!phase_move_q && !freeze_i) begin
          input_code_o <= data_o;
          if (mode_q == DBDL_MODE_SINGLE) begin
            true_code_o       <= data_o;
            complement_code_o <= CODE_FULL - data_o;
          end
        end else if (phase_move_q) begin
          // copy input register into converter
          true_code_o       <= input_code_o;
          complement_code_o <= CODE_FULL - input_code_o;
        end
      end
    end
  end

endmodule : dbdl_ctrl
`default_nettype wire

// file: dbdl_ctrl_sva.sv
// checker for the converter latch controller pins
`timescale 1ns/1ps
`default_nettype none
module dbdl_ctrl_sva #(
  parameter int unsigned STROBE_CYC = dbdl_pkg::STROBE_CYC
) (
  // clock and control
  input wire logic                        clk_i,
  input wire logic                        reset_i,
  input wire logic                        ce_i,
  input wire logic                        freeze_i,
  // controller outputs
  input wire logic                        cmd_ready_o,
  input wire logic [dbdl_pkg::CODE_W-1:0] data_o,
  input wire logic                        input_select_n_o,
  input wire logic                        input_latch_enable_o,
  input wire logic                        first_write_strobe_n_o,
  input wire logic                        second_write_strobe_n_o,
  input wire logic                        transfer_select_n_o,
  input wire logic [dbdl_pkg::CODE_W-1:0] true_code_o,
  input wire logic [dbdl_pkg::CODE_W-1:0] complement_code_o
);
  import dbdl_pkg::*;
  logic [7:0] low_cnt_q;

  // low-time counter; saturates so a stuck strobe cannot wrap to a pass
  always_ff @(posedge clk_i) begin
    if (reset_i || first_write_strobe_n_o) begin
      low_cnt_q <= 8'h00;
    end else if (low_cnt_q != 8'hFF) begin
      low_cnt_q <= low_cnt_q + 8'h01;
    end
  end

  // reset leaves every strobe and select idle and the output at zero
  a_reset_idle: assert property (@(posedge clk_i) reset_i |=>
    (first_write_strobe_n_o && second_write_strobe_n_o && input_select_n_o
     && transfer_select_n_o && true_code_o == 8'h00))
    else $error("controls not idle after reset");
  a_complement_code: assert property (@(posedge clk_i) disable iff (reset_i)
    complement_code_o == 8'hFF - true_code_o)
    else $error("complement code mismatch");
  a_latch_freeze: assert property (@(posedge clk_i) disable iff (reset_i)
    $past(ce_i) && !$past(reset_i) |->
    input_latch_enable_o == !$past(freeze_i))
    else $error("latch enable does not follow freeze");
  a_data_steady: assert property (@(posedge clk_i) disable iff (reset_i)
    !first_write_strobe_n_o && !cmd_ready_o ##1 !first_write_strobe_n_o
    |-> $stable(data_o))
    else $error("data moved while strobe low");
  a_data_hold: assert property (@(posedge clk_i) disable iff (reset_i)
    $rose(first_write_strobe_n_o) && !cmd_ready_o |=> $stable(data_o))
    else $error("data hold after strobe too short");
  a_strobe_width: assert property (@(posedge clk_i) disable iff (reset_i)
    $rose(first_write_strobe_n_o) && !cmd_ready_o |->
    low_cnt_q >= STROBE_CYC)
    else $error("write strobe too short");
  a_strobe_select: assert property (@(posedge clk_i) disable iff (reset_i)
    !first_write_strobe_n_o |-> !input_select_n_o)
    else $error("first strobe without input select");
  a_converter_hold: assert property (@(posedge clk_i) disable iff (reset_i)
    (second_write_strobe_n_o || transfer_select_n_o) [*8] |->
    $stable(true_code_o))
    else $error("converter code moved while closed");
endmodule : dbdl_ctrl_sva

bind dbdl_ctrl dbdl_ctrl_sva #(.STROBE_CYC(STROBE_CYC)) i_dbdl_ctrl_sva (
  .clk_i(clk_i), .reset_i(reset_i), .ce_i(ce_i), .freeze_i(freeze_i),
  .cmd_ready_o(cmd_ready_o), .data_o(data_o),
  .input_select_n_o(input_select_n_o),
  .input_latch_enable_o(input_latch_enable_o),
  .first_write_strobe_n_o(first_write_strobe_n_o),
  .second_write_strobe_n_o(second_write_strobe_n_o),
  .transfer_select_n_o(transfer_select_n_o),
  .true_code_o(true_code_o), .complement_code_o(complement_code_o));
`default_nettype wire

// file: dbdl_dev_model.sv
// behavioural model of the double-buffered converter latches
`timescale 1ns/1ps
`default_nettype none
module dbdl_dev_model (
  // pins from the controller
  input  wire logic [dbdl_pkg::CODE_W-1:0] data_i,
  input  wire logic                        input_select_n_i,
  input  wire logic                        latch_enable_i,
  input  wire logic                        first_write_strobe_n_i,
  input  wire logic                        second_write_strobe_n_i,
  input  wire logic                        transfer_select_n_i,
  // latch contents and current steering weights
  output logic      [dbdl_pkg::CODE_W-1:0] input_reg_o,
  output logic      [dbdl_pkg::CODE_W-1:0] convert_reg_o,
  output logic      [dbdl_pkg::CODE_W-1:0] true_current_o,
  output logic      [dbdl_pkg::CODE_W-1:0] complement_current_o
);
  import dbdl_pkg::*;
  // only a firm low opens a latch: floating pins read as high
  wire open_in  = (input_select_n_i === 1'b0) && (latch_enable_i !== 1'b0)
                  && (first_write_strobe_n_i === 1'b0);
  wire open_cnv = (second_write_strobe_n_i === 1'b0)
                  && (transfer_select_n_i === 1'b0);

  // input latch; closing on the rising strobe keeps the last byte
  always_latch begin
    if (open_in) begin
      input_reg_o <= data_i;
    end
  end

  // converter latch, open only while both of its controls are low
  always_latch begin
    if (open_cnv) begin
      convert_reg_o <= input_reg_o;
    end
  end

  // a 1 bit steers to the true output, a 0 bit to the complement
  assign true_current_o       = convert_reg_o;
  assign complement_current_o = ~convert_reg_o;
endmodule : dbdl_dev_model
`default_nettype wire

// file: dbdl_ctrl_tb.sv
// self-checking bench for the converter latch controller
`timescale 1ns/1ps
`default_nettype none
module dbdl_ctrl_tb;
  import dbdl_pkg::*;
  logic       clk_i, reset_i, ce_i, freeze_i, cmd_valid_i, cmd_ready_o;
  logic       done_o, sel_n, le, stb1_n, stb2_n, move_n;
  dbdl_mode_t mode_i;
  dbdl_op_t   cmd_op_i;
  logic [7:0] cmd_data_i, data_o, input_code_o, true_code_o, compl_code_o;
  logic [7:0] dev_in, dev_cnv, dev_true, dev_comp;
  logic [7:0] codes [4] = '{8'h00, 8'hFF, 8'h80, 8'h01};
  int         failures = 0;
  int         checked  = 0;

  // short strobe and hold keep the run brief
  dbdl_ctrl #(.STROBE_CYC(2), .HOLD_CYC(1), .SETUP_CYC(1)) i_dbdl_ctrl (
    .clk_i(clk_i), .reset_i(reset_i), .ce_i(ce_i), .mode_i(mode_i),
    .freeze_i(freeze_i), .cmd_valid_i(cmd_valid_i), .cmd_op_i(cmd_op_i),
    .cmd_data_i(cmd_data_i), .cmd_ready_o(cmd_ready_o), .done_o(done_o),
    .data_o(data_o), .input_select_n_o(sel_n), .input_latch_enable_o(le),
    .first_write_strobe_n_o(stb1_n), .second_write_strobe_n_o(stb2_n),
    .transfer_select_n_o(move_n), .input_code_o(input_code_o),
    .true_code_o(true_code_o), .complement_code_o(compl_code_o));
  dbdl_dev_model i_dbdl_dev_model (
    .data_i(data_o), .input_select_n_i(sel_n), .latch_enable_i(le),
    .first_write_strobe_n_i(stb1_n), .second_write_strobe_n_i(stb2_n),
    .transfer_select_n_i(move_n), .input_reg_o(dev_in),
    .convert_reg_o(dev_cnv), .true_current_o(dev_true),
    .complement_current_o(dev_comp));

  // clock
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  task automatic check(input logic [7:0] seen, exp, input string msg);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("FAIL %0t %s", $time, msg);
    end
  endtask : check

  // request held until taken, then wait for the finish pulse
  task automatic do_req(input dbdl_op_t op, input logic [7:0] d);
    int n;
    n = 0;
    cmd_op_i    = op;
    cmd_data_i  = d;
    cmd_valid_i = 1'b1;
    while (cmd_ready_o !== 1'b1 && n < 200) begin
      @(negedge clk_i);
      n++;
    end
    @(negedge clk_i);
    cmd_valid_i = 1'b0;
    n = 0;
    while (done_o !== 1'b1 && n < 200) begin
      @(negedge clk_i);
      n++;
    end
    check({7'h00, done_o}, 8'h01, "request never finished");
    @(negedge clk_i);
  endtask : do_req

  // mode is only taken while idle, one cycle late
  task automatic set_mode(input dbdl_mode_t m);
    mode_i = m;
    repeat (3) @(negedge clk_i);
  endtask : set_mode

  task automatic t_double;
    do_req(DBDL_OP_LOAD_MOVE, 8'h11);
    check(dev_cnv, 8'h11, "load and transfer");
    do_req(DBDL_OP_LOAD, 8'hA5);
    check(dev_in, 8'hA5, "input register load");
    check(input_code_o, 8'hA5, "input code mirror");
    check(data_o, 8'hA5, "data pins hold byte");
    check(dev_cnv, 8'h11, "converter held during load");
    do_req(DBDL_OP_TRANSFER, 8'h00);
    check(dev_cnv, 8'hA5, "transfer to converter");
    check(true_code_o, 8'hA5, "true code");
    check(compl_code_o, 8'h5A, "complement code");
    freeze_i = 1'b1;
    repeat (2) @(negedge clk_i);
    do_req(DBDL_OP_LOAD, 8'h3C);
    check(dev_in, 8'hA5, "frozen input register");
    check(input_code_o, 8'hA5, "frozen input code");
    freeze_i = 1'b0;
    for (int i = 0; i < 4; i++) begin
      do_req(DBDL_OP_LOAD_MOVE, codes[i]);
      check(dev_true, codes[i], "true weight");
      check(dev_comp, 8'hFF - codes[i], "complement weight");
    end
    // a low enable holds every pin, latch enable too, against freeze
    ce_i     = 1'b0;
    freeze_i = 1'b1;
    repeat (2) @(negedge clk_i);
    check({7'h00, le}, 8'h01, "enable low holds pins");
    freeze_i = 1'b0;
    ce_i     = 1'b1;
    @(negedge clk_i);
    $display("test double done");
  endtask : t_double

  task automatic t_single;
    set_mode(DBDL_MODE_SINGLE);
    do_req(DBDL_OP_LOAD, 8'h81);
    check(dev_cnv, 8'h81, "single buffered update");
    do_req(DBDL_OP_TRANSFER, 8'h42);
    check(dev_cnv, 8'h81, "transfer has no effect");
    $display("test single done");
  endtask : t_single

  task automatic t_flow;
    set_mode(DBDL_MODE_FLOW);
    for (int i = 0; i < 4; i++) begin
      do_req(DBDL_OP_LOAD, codes[3 - i]);
      check(dev_cnv, codes[3 - i], "flow through");
      check(true_code_o, codes[3 - i], "flow code");
    end
    set_mode(DBDL_MODE_DOUBLE);
    $display("test flow done");
  endtask : t_flow

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : report_and_stop

  // main sequence
  initial begin
    reset_i     = 1'b1;
    ce_i        = 1'b1;
    freeze_i    = 1'b0;
    mode_i      = DBDL_MODE_DOUBLE;
    cmd_valid_i = 1'b0;
    cmd_op_i    = DBDL_OP_LOAD;
    cmd_data_i  = 8'h00;
    repeat (4) @(negedge clk_i);
    reset_i = 1'b0;
    repeat (2) @(negedge clk_i);
    check(compl_code_o, 8'hFF, "complement after reset");
    check({4'h0, sel_n, stb1_n, stb2_n, move_n}, 8'h0F, "idle");
    check({5'h00, cmd_ready_o, le, done_o}, 8'h06, "ready");
    t_double();
    t_single();
    t_flow();
    report_and_stop();
  end

  // watchdog: tests need well under a thousand cycles
  initial begin
    #(40 * 5000);
    failures++;
    report_and_stop();
  end
endmodule : dbdl_ctrl_tb
`default_nettype wire
